// ==== inc/isd_pkg.sv ====
// package: register map, state codes and carriers for the i2c state diagnostic block
// Overview of operation
// - a data byte steps through eight consecutive codes, bit 7 first and bit 0 last, in ascending code order.
// - after the data bits comes the data acknowledge state, and a second-half acknowledge state is used only on a negative acknowledge.
// - a stop condition takes two successive states, first part then second part, each with its own code.
// - in 7-bit addressing one shared code marks the address acknowledge phase after the address byte.
// - in 10-bit addressing that same code marks the acknowledge of the second address byte.
// - the least significant address bit, the direction bit in 7-bit mode or bit 0 of the second 10-bit byte, has one code.
// - the first 10-bit address byte is shifted msb first through eight consecutive codes, ending with its direction bit.
// - after the first 10-bit address byte a dedicated acknowledge state comes before the second address byte.
// - address bits 7 down to 1 of the 7-bit byte or second 10-bit byte step through consecutive codes from their start value.
// - with the readback select bit clear, the baud-rate high and low byte registers read back the reload value.
// - with the readback select bit set, those registers read back the live baud-rate counter instead.
// - the diagnostic control register has its own address and resets to zero, normal readback.
// - a read-only diagnostic state register shows raw clock in, raw data in, the stop-count signal and the five-bit state code.
// - the high and low byte registers together form the sixteen-bit reload value.
`default_nettype none
package isd_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [11:0] ISD_ADDR_RELOAD_HI = 12'hf53;
    localparam logic [11:0] ISD_ADDR_RELOAD_LO = 12'hf54;
    localparam logic [11:0] ISD_ADDR_READBACK_SELECT_ST   = 12'hf55;
    localparam logic [11:0] ISD_ADDR_READBACK_SELECT_SEL  = 12'hf56;
    localparam logic [11:0] ISD_ADDR_CTRL      = 12'hf50;
    localparam logic [7:0]  ISD_RELOAD_RST     = 8'hff;
    localparam logic [7:0]  ISD_READBACK_SELECT_SEL_RST   = 8'h00;
    localparam int          ISD_SEL_BIT        = 0;
    localparam int          ISD_CTRL_GO_BIT    = 0;
    localparam int          ISD_CTRL_TEN_BIT   = 1;
    localparam int          ISD_CTRL_NACK_BIT  = 2;
    localparam int          ISD_CTRL_STOP_BIT  = 3;
    localparam logic [15:0] ISD_CNT_ONE        = 16'h0001;
    localparam logic [2:0]  ISD_BIT_LAST       = 3'h7;

    // ----------------------------------------
    // state codes
    // ----------------------------------------
    localparam logic [4:0] ISD_ST_IDLE    = 5'h00;
    localparam logic [4:0] ISD_ST_START   = 5'h01;
    localparam logic [4:0] ISD_ST_DATA7   = 5'h02;
    localparam logic [4:0] ISD_ST_DATA0   = 5'h09;
    localparam logic [4:0] ISD_ST_DACK    = 5'h0a;
    localparam logic [4:0] ISD_ST_DNACK   = 5'h0b;
    localparam logic [4:0] ISD_ST_STOP1   = 5'h0c;
    localparam logic [4:0] ISD_ST_STOP2   = 5'h0d;
    localparam logic [4:0] ISD_ST_AACK    = 5'h0e;
    localparam logic [4:0] ISD_ST_ALSB    = 5'h0f;
    localparam logic [4:0] ISD_ST_TA7     = 5'h10;
    localparam logic [4:0] ISD_ST_TA0     = 5'h17;
    localparam logic [4:0] ISD_ST_TACK    = 5'h18;
    localparam logic [4:0] ISD_ST_ADDR7   = 5'h19;
    localparam logic [4:0] ISD_ST_ADDR1   = 5'h1f;

    typedef enum {
        ISD_IDLE, ISD_START, ISD_TA, ISD_TACK, ISD_ADDR, ISD_ALSB, ISD_AACK,
        ISD_DATA, ISD_DACK, ISD_DNACK, ISD_STOP1, ISD_STOP2
    } isd_state_t;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } isd_bus_req_t;

    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       stop_cnt;
        logic [4:0] code;
    } isd_readback_select_t;
endpackage : isd_pkg
`default_nettype wire

// ==== src/isd_baud_counter.sv ====
// module: sixteen-bit baud-rate down counter producing a one-cycle bit tick
`timescale 1ns/1ns
`default_nettype none
module isd_baud_counter
    import isd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic [15:0] reload_i,
    input  wire logic        run_i,
    output logic      [15:0] count_o,
    output logic             tick_o
);
    // counts down to one, then reloads; a zero reload behaves like one
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_o <= 16'hffff;
            tick_o  <= 1'b0;
        end else if (!run_i) begin
            count_o <= reload_i;
            tick_o  <= 1'b0;
        end else if (count_o <= ISD_CNT_ONE) begin
            count_o <= reload_i;
            tick_o  <= 1'b1;
        end else begin
            count_o <= count_o - ISD_CNT_ONE;
            tick_o  <= 1'b0;
        end
    end
endmodule // isd_baud_counter
`default_nettype wire

// ==== src/isd_state_seq.sv ====
// module: transfer state sequencer and its five-bit diagnostic code
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module isd_state_seq
    import isd_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       tick_i,
    input  wire logic       go_i,
    input  wire logic       ten_bit_i,
    input  wire logic       nack_i,
    input  wire logic       stop_i,
    output logic      [4:0] code_o,
    output logic            stop_cnt_o,
    output logic            busy_o
);
    isd_state_t state_q;
    logic [2:0] bit_q;
    logic       second_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q  <= ISD_IDLE;
            bit_q    <= 3'h0;
            second_q <= 1'b0;
        end else if (tick_i) begin
            bit_q <= 3'h0;
            case (state_q)
                ISD_IDLE:  if (go_i) state_q <= ISD_START;
                ISD_START: begin
                    second_q <= 1'b0;
                    state_q  <= ten_bit_i ? ISD_TA : ISD_ADDR;
                end
                ISD_TA: begin
                    bit_q <= bit_q + 3'h1;
                    if (bit_q == ISD_BIT_LAST) state_q <= ISD_TACK;
                end
                ISD_TACK: begin
                    second_q <= 1'b1;
                    state_q  <= ISD_ADDR;
                end
                ISD_ADDR: begin
                    bit_q <= bit_q + 3'h1;
                    if (bit_q == (ISD_BIT_LAST - 3'h1)) state_q <= ISD_ALSB;
                end
                ISD_ALSB:  state_q <= ISD_AACK;
                ISD_AACK:  state_q <= ISD_DATA;
                ISD_DATA: begin
                    bit_q <= bit_q + 3'h1;
                    if (bit_q == ISD_BIT_LAST) state_q <= ISD_DACK;
                end
                ISD_DACK:  state_q <= nack_i ? ISD_DNACK : (stop_i ? ISD_STOP1 : ISD_DATA);
                ISD_DNACK: state_q <= ISD_STOP1;
                ISD_STOP1: state_q <= ISD_STOP2;
                ISD_STOP2: state_q <= ISD_IDLE;
                default:   state_q <= ISD_IDLE;
            endcase
        end
    end

    assign busy_o     = (state_q != ISD_IDLE);
    assign stop_cnt_o = (state_q == ISD_STOP1) || (state_q == ISD_STOP2);

    always_comb begin
        case (state_q)
            ISD_IDLE:  code_o = ISD_ST_IDLE;
            ISD_START: code_o = ISD_ST_START;
            ISD_TA:    code_o = ISD_ST_TA7 + {2'b00, bit_q};
            ISD_TACK:  code_o = ISD_ST_TACK;
            ISD_ADDR:  code_o = ISD_ST_ADDR7 + {2'b00, bit_q};
            ISD_ALSB:  code_o = ISD_ST_ALSB;
            ISD_AACK:  code_o = ISD_ST_AACK;
            ISD_DATA:  code_o = ISD_ST_DATA7 + {2'b00, bit_q};
            ISD_DACK:  code_o = ISD_ST_DACK;
            ISD_DNACK: code_o = ISD_ST_DNACK;
            ISD_STOP1: code_o = ISD_ST_STOP1;
            ISD_STOP2: code_o = ISD_ST_STOP2;
            default:   code_o = ISD_ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_data_last;
        (code_o == ISD_ST_DATA0) && tick_i;
    endsequence

    sequence s_data_ack;
        code_o == ISD_ST_DACK;
    endsequence

    AST_IDLE_ZERO: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state_q == ISD_IDLE) |-> (code_o == ISD_ST_IDLE))
        else $error("idle code not zero");
    AST_START_AFTER_IDLE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (code_o == ISD_ST_IDLE) ##1 (code_o != ISD_ST_IDLE) |-> (code_o == ISD_ST_START))
        else $error("idle not followed by start");
    AST_DATA_STEP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state_q == ISD_DATA && tick_i && bit_q != ISD_BIT_LAST)
        |=> (code_o == $past(code_o) + 5'h01))
        else $error("data code did not step");
    AST_DATA_TO_ACK: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_data_last |=> s_data_ack)
        else $error("data bit 0 not followed by ack");
    AST_NACK_ONLY: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (code_o == ISD_ST_DACK && tick_i && !nack_i) |=> (code_o != ISD_ST_DNACK))
        else $error("second-half ack without nack");
    AST_STOP_TWO: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (code_o == ISD_ST_STOP1 && tick_i) |=> (code_o == ISD_ST_STOP2))
        else $error("stop parts out of order");
    AST_LSB_TO_ACK: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (code_o == ISD_ST_ALSB && tick_i) |=> (code_o == ISD_ST_AACK))
        else $error("address lsb not followed by ack");
    AST_ADDR1_TO_LSB: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (code_o == ISD_ST_ADDR1 && tick_i) |=> (code_o == ISD_ST_ALSB))
        else $error("address bit 1 not followed by lsb");
    AST_TA_TO_TACK: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (code_o == ISD_ST_TA0 && tick_i) |=> (code_o == ISD_ST_TACK))
        else $error("first byte not followed by its ack");
    AST_TACK_TO_ADDR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (code_o == ISD_ST_TACK && tick_i) |=> (code_o == ISD_ST_ADDR7))
        else $error("second byte does not start at bit 7");
endmodule // isd_state_seq
`default_nettype wire

// ==== src/isd_top.sv ====
// module: register slave tying the diagnostic readback to the sequencer and baud counter
`timescale 1ns/1ns
`default_nettype none
module isd_top
    import isd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic        raw_serial_clock_in_i,
    input  wire logic        raw_serial_data_in_i,
    output logic      [7:0]  rdata_o,
    output logic      [4:0]  controller_state_code_o,
    output logic             busy_o
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0]  reload_high_byte_q;
    logic [7:0]  reload_low_byte_q;
    logic [7:0]  diagnostic_readback_select_q;
    logic [3:0]  ctrl_q;
    logic [15:0] count;
    logic        tick;
    logic [4:0]  code;
    logic        stop_cnt;
    logic        busy;
    isd_readback_select_t   readback_select;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reload_high_byte_q <= ISD_RELOAD_RST;
            reload_low_byte_q  <= ISD_RELOAD_RST;
        end else if (wr_i) begin
            if (addr_i == ISD_ADDR_RELOAD_HI) reload_high_byte_q <= wdata_i;
            if (addr_i == ISD_ADDR_RELOAD_LO) reload_low_byte_q  <= wdata_i;
        end
    end

    // only the select bit is writable; upper bits read zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            diagnostic_readback_select_q <= ISD_READBACK_SELECT_SEL_RST;
        end else if (wr_i && addr_i == ISD_ADDR_READBACK_SELECT_SEL) begin
            diagnostic_readback_select_q <= {7'h00, wdata_i[ISD_SEL_BIT]};
        end
    end

    // go self-clears when the transfer starts so one write makes one transfer
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= 4'h0;
        end else if (wr_i && addr_i == ISD_ADDR_CTRL) begin
            ctrl_q <= wdata_i[3:0];
        end else if (busy) begin
            ctrl_q[ISD_CTRL_GO_BIT] <= 1'b0;
        end
    end

    // ----------------------------------------
    // sub-blocks
    // ----------------------------------------
    isd_baud_counter u_cnt (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .reload_i ({reload_high_byte_q, reload_low_byte_q}),
        .run_i    (1'b1),
        .count_o  (count),
        .tick_o   (tick)
    );

    isd_state_seq u_seq (
        .clk_i      (clk_i),
        .arst_n_i   (arst_n_i),
        .tick_i     (tick),
        .go_i       (ctrl_q[ISD_CTRL_GO_BIT]),
        .ten_bit_i  (ctrl_q[ISD_CTRL_TEN_BIT]),
        .nack_i     (ctrl_q[ISD_CTRL_NACK_BIT]),
        .stop_i     (ctrl_q[ISD_CTRL_STOP_BIT]),
        .code_o     (code),
        .stop_cnt_o (stop_cnt),
        .busy_o     (busy)
    );

    assign readback_select = '{scl: raw_serial_clock_in_i, sda: raw_serial_data_in_i,
                    stop_cnt: stop_cnt, code: code};

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                ISD_ADDR_RELOAD_HI: rdata_o <= diagnostic_readback_select_q[ISD_SEL_BIT]
                                               ? count[15:8] : reload_high_byte_q;
                ISD_ADDR_RELOAD_LO: rdata_o <= diagnostic_readback_select_q[ISD_SEL_BIT]
                                               ? count[7:0] : reload_low_byte_q;
                ISD_ADDR_READBACK_SELECT_ST:   rdata_o <= readback_select;
                ISD_ADDR_READBACK_SELECT_SEL:  rdata_o <= diagnostic_readback_select_q;
                ISD_ADDR_CTRL:      rdata_o <= {4'h0, ctrl_q};
                default:            rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            controller_state_code_o <= ISD_ST_IDLE;
            busy_o                  <= 1'b0;
        end else begin
            controller_state_code_o <= code;
            busy_o                  <= busy;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_NORMAL_READ: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (rd_i && addr_i == ISD_ADDR_RELOAD_LO && !diagnostic_readback_select_q[ISD_SEL_BIT])
        |=> (rdata_o == $past(reload_low_byte_q)))
        else $error("normal read did not return reload");
    AST_READBACK_SELECT_READ: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (rd_i && addr_i == ISD_ADDR_RELOAD_HI && diagnostic_readback_select_q[ISD_SEL_BIT])
        |=> (rdata_o == $past(count[15:8])))
        else $error("diagnostic read did not return counter");
    AST_STATE_READ: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (rd_i && addr_i == ISD_ADDR_READBACK_SELECT_ST) |=> (rdata_o[4:0] == $past(code)))
        else $error("state register does not show code");
endmodule // isd_top
`default_nettype wire

// ==== testbench/i2c_state_readback_select_readback_test.sv ====
// testbench: register readback and state code sequences of the diagnostic block
`timescale 1ns/1ns
`default_nettype none
module i2c_state_readback_select_readback_test;
    import isd_pkg::*;
    logic        clk_i;
    logic        arst_n_i;
    logic [11:0] addr_i;
    logic [7:0]  wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic        scl_low;
    logic        sda_low;
    logic        scl;
    logic        sda;
    logic [7:0]  rdata_o;
    logic [4:0]  code_o;
    logic        busy_o;
    logic [4:0]  last_code;
    logic [4:0]  seen[$];
    logic [4:0]  exp_q[$];
    logic        arm;
    logic [7:0]  rv;
    logic [7:0]  rv2;
    int          failures;
    int          n_tests;
    int          cycles;

    // ----------------------------------------
    // design and far side
    // ----------------------------------------
    isd_top DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .raw_serial_clock_in_i(scl), .raw_serial_data_in_i(sda),
        .rdata_o(rdata_o), .controller_state_code_o(code_o), .busy_o(busy_o));
    isd_bus_partner PARTNER (.hold_scl_low_i(scl_low), .hold_sda_low_i(sda_low),
        .scl_o(scl), .sda_o(sda));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // records every change of the state code while a transfer is watched
    always @(posedge clk_i) begin
        if (arm && code_o !== last_code) seen.push_back(code_o);
        last_code <= code_o;
    end

    // hang guard: one full count-down from the reset reload plus the transfers fit under this
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            end_sim();
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp || $isunknown(got)) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // strobe is dropped and one edge passes, so calls may follow each other directly
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd_reg(a, d);
        chk(what, exp, d);
    endtask

    task automatic add_rng(input int a, input int b);
        for (int c = a; c <= b; c++) begin
            exp_q.push_back(5'(c));
        end
    endtask

    task automatic run_xfer(input logic [7:0] ctl);
        int         i;
        logic       did;
        logic [7:0] d;
        seen.delete();
        did = 1'b0;
        arm = 1'b1;
        wr_reg(ISD_ADDR_CTRL, ctl);
        i = 0;
        while (!(seen.size() > 0 && code_o === ISD_ST_IDLE) && i < 3000) begin
            if (code_o === ISD_ST_STOP1 && !did) begin
                did = 1'b1;
                rd_reg(ISD_ADDR_READBACK_SELECT_ST, d);
                chk("state reg in stop", 8'hac, d);
                chk("busy in stop", 8'h01, {7'h00, busy_o});
            end
            @(posedge clk_i);
            i++;
        end
        // one more edge so the recorder logs the final idle code before it is disarmed
        @(posedge clk_i);
        arm = 1'b0;
        chk("busy after stop", 8'h00, {7'h00, busy_o});
        chk("code count", 8'(exp_q.size()), 8'(seen.size()));
        for (int k = 0; k < exp_q.size() && k < seen.size(); k++) begin
            chk("state code", {3'h0, exp_q[k]}, {3'h0, seen[k]});
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        arst_n_i = 1'b0;
        addr_i = 12'h000;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        scl_low = 1'b1;
        sda_low = 1'b0;
        arm = 1'b0;
        failures = 0;
        n_tests = 0;
        cycles = 0;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        rd_chk("reload hi reset", ISD_ADDR_RELOAD_HI, 8'hff);
        rd_chk("reload lo reset", ISD_ADDR_RELOAD_LO, 8'hff);
        rd_chk("select reset", ISD_ADDR_READBACK_SELECT_SEL, 8'h00);
        wr_reg(ISD_ADDR_READBACK_SELECT_ST, 8'hff);
        rd_chk("idle state reg", ISD_ADDR_READBACK_SELECT_ST, 8'h40);
        wr_reg(12'hf57, 8'h5a);
        rd_chk("unmapped", 12'hf57, 8'h00);
        wr_reg(ISD_ADDR_READBACK_SELECT_SEL, 8'hff);
        rd_chk("select reserved bits", ISD_ADDR_READBACK_SELECT_SEL, 8'h01);
        // two reads back to back must see the live counter one cycle apart
        addr_i <= ISD_ADDR_RELOAD_LO;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        #1 rv = rdata_o;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 rv2 = rdata_o;
        @(posedge clk_i);
        chk("live counter step", rv - 8'h01, rv2);
        wr_reg(ISD_ADDR_READBACK_SELECT_SEL, 8'h00);
        rd_chk("reload lo normal", ISD_ADDR_RELOAD_LO, 8'hff);
        wr_reg(ISD_ADDR_RELOAD_HI, 8'h00);
        wr_reg(ISD_ADDR_RELOAD_LO, 8'h10);
        rd_chk("reload hi written", ISD_ADDR_RELOAD_HI, 8'h00);
        rd_chk("reload lo written", ISD_ADDR_RELOAD_LO, 8'h10);
        wr_reg(ISD_ADDR_READBACK_SELECT_SEL, 8'h01);
        // a new reload only reaches the counter when it next counts down to one
        rd_chk("counter hi", ISD_ADDR_RELOAD_HI, 8'hff);
        repeat (65536) @(posedge clk_i);
        rd_chk("counter hi reloaded", ISD_ADDR_RELOAD_HI, 8'h00);
        wr_reg(ISD_ADDR_READBACK_SELECT_SEL, 8'h00);
        scl_low <= 1'b0;
        sda_low <= 1'b1;
        // 7-bit address, one data byte, acknowledged, then stop
        exp_q.delete();
        add_rng(1, 1);
        add_rng(25, 31);
        add_rng(15, 15);
        add_rng(14, 14);
        add_rng(2, 10);
        add_rng(12, 13);
        add_rng(0, 0);
        run_xfer(8'h09);
        // 7-bit address, byte ends on a negative acknowledge
        exp_q.delete();
        add_rng(1, 1);
        add_rng(25, 31);
        add_rng(15, 15);
        add_rng(14, 14);
        add_rng(2, 13);
        add_rng(0, 0);
        run_xfer(8'h0d);
        // 10-bit address: first byte, its acknowledge, then second byte
        exp_q.delete();
        add_rng(1, 1);
        add_rng(16, 31);
        add_rng(15, 15);
        add_rng(14, 14);
        add_rng(2, 10);
        add_rng(12, 13);
        add_rng(0, 0);
        run_xfer(8'h0b);
        end_sim();
    end
endmodule // i2c_state_readback_select_readback_test
`default_nettype wire

// ==== testbench/isd_bus_partner.sv ====
// partner model: serial bus lines as seen from the slave side
`timescale 1ns/1ns
`default_nettype none
module isd_bus_partner (
    input  wire logic hold_scl_low_i,
    input  wire logic hold_sda_low_i,
    output logic      scl_o,
    output logic      sda_o
);
    // ----------------------------------------
    // open-drain lines
    // ----------------------------------------
    // both lines carry a pull-up, so a released line reads high
    assign scl_o = hold_scl_low_i ? 1'b0 : 1'b1;
    assign sda_o = hold_sda_low_i ? 1'b0 : 1'b1;
endmodule // isd_bus_partner
`default_nettype wire
